/* File: inc/jpa_pkg.sv */
/*
 file: constants and types of the tap port-access arbiter.
 assumes: imported whole by the arbiter module.
*/
package jpa_pkg;
   // ------
   // command word layout
   // ------
   localparam int CMD_W   = 32;     // access register width
   localparam int DATA_W  = 16;     // port data width
   localparam int ADDR_W  = 10;     // port address width
   localparam int OP_W    = 4;      // operation field width
   localparam int DAT_LSB = 0;      // write data field
   localparam int ADR_LSB = 16;     // address field
   localparam int OP_LSB  = 26;     // operation field
   // ------
   // operation codes
   // ------
   localparam logic [3:0] OP_NOP   = 4'h0;
   localparam logic [3:0] OP_READ  = 4'h1;
   localparam logic [3:0] OP_WRITE = 4'h2;
   // ------
   // special addresses and values
   // ------
   localparam logic [9:0]  ADR_LOCK = 10'h000;
   localparam logic [9:0]  ADR_AUX  = 10'h002;
   localparam logic [9:0]  ADR_RST  = 10'h003;
   localparam logic [15:0] LOCK_ON  = 16'h0001;
   localparam logic [15:0] LOCK_OFF = 16'h0000;
   localparam logic [15:0] AUX_ON   = 16'h0001;
   localparam logic [15:0] REG_RST  = 16'h0000;
   localparam logic [15:0] UPPER_Z  = 16'h0000;
   // ------
   // timing counts in port clock cycles, and the processor fifo depth
   // ------
   localparam int LOCK_WAKE_CYC = 10;  // wake lock release bound
   localparam int TAP_DONE_CYC  = 10;  // tap access completion bound
   localparam int FIFO_DEPTH    = 15;  // processor path fifo depth
   // ------
   // synchroniser bit positions
   // ------
   localparam int SY_TCK = 0;
   localparam int SY_TDI = 1;
   localparam int SY_CAP = 2;
   localparam int SY_SH  = 3;
   localparam int SY_UPD = 4;
   localparam int SY_MIS = 5;
   localparam int SY_W   = 6;
   // arbiter owner states
   typedef enum logic [1:0] {ARB_IDLE, ARB_FAB, ARB_TAP} jpa_arb_t;
endpackage

/* File: rtl/jpa_arbiter.sv */
/*
 file: tap access register, command decode and per-transaction
 arbiter between tap and fabric for the reconfig_port registers,
 plus the processor command path with its two fifos.
 assumes: tap controller state levels, tck, tdi and clk_missing
 come from outside the clk domain; fabric and processor signals
 are synchronous to clk (the port_clock).
*/
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Contract
// - tap read: command scan, then result scan
// - read result captured into low half
// - captured upper half zero, lsb first
// - early scan captures old held data
// - reads pipeline, command in, result out
// - fields: data 15:0, addr 25:16, op 29:26
// - op 0 nop, 1 read, 2 write
// - tap write done within ten cycles
// - aux enable write keeps stored value
// - fabric queued behind tap transaction
// - tap waits for fabric in progress
// - busy from update to completion
// - fabric ready withheld while tap busy; a fabric grant made in the cycle busy rises still strobes while busy is high
// - modified set by tap write, cleared
// - address zero writes lock or unlock
// - lock refuses fabric requests
// - lock held at clock wake, ten cycles
// - missing clock selects internal oscillator
// - write address three resets converter
// - processor path with two fifos
// - processor path disables tap access
// - alarms raise processor interrupt
module jpa_arbiter
   import jpa_pkg::*;
#(
   parameter int REG_AW = 4,           // stored register index width
   parameter int FD     = FIFO_DEPTH,  // processor fifo depth
   parameter int WAKE   = LOCK_WAKE_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // tap side; inputs asynchronous, tdo from a clk flop
   input  wire logic                 tck,
   input  wire logic                 tdi,
   input  wire logic                 tap_capture,
   input  wire logic                 tap_shift,
   input  wire logic                 tap_update,
   input  wire logic                 port_access_instruction,
   output logic                      tdo,
   // fabric reconfig_port
   input  wire logic                 port_en,
   input  wire logic                 port_we,
   input  wire logic [ADDR_W-1:0]    port_addr,
   input  wire logic [DATA_W-1:0]    port_di,
   output logic [DATA_W-1:0]         port_do,
   output logic                      port_ready_strobe,
   output logic                      tap_busy_flag,
   output logic                      tap_wrote_flag,
   output logic                      tap_lock_flag,
   // converter side
   input  wire logic                 configured,
   input  wire logic                 clk_missing,
   output logic                      aux_enable,
   output logic                      conv_reset,
   output logic                      osc_select,
   // processor path
   input  wire logic                 proc_en,
   input  wire logic                 proc_cmd_valid,
   input  wire logic [CMD_W-1:0]     proc_cmd_data,
   output logic                      proc_cmd_ready,
   output logic                      proc_rd_valid,
   output logic [CMD_W-1:0]          proc_rd_data,
   input  wire logic                 proc_rd_ready,
   input  wire logic                 over_temp_alarm,
   input  wire logic [6:0]           alarm_flags,
   output logic                      proc_irq
);
   localparam int DEPTH = 1 << REG_AW;
   localparam int CW    = $clog2(FD + 1);
   localparam logic [CW-1:0] FD_C = CW'(FD);
   localparam logic [3:0] WAKE_C = 4'(WAKE - 1);

   // ------
   // state
   // ------
   typedef struct packed {
      logic [SY_W-1:0]             s1;       // first sync stage
      logic [SY_W-1:0]             s2;       // second sync stage
      logic                        tck_d;    // tck edge detect
      logic [1:0]                  ins_s;    // instruction select sync
      jpa_arb_t                    arb;      // port owner
      logic [CMD_W-1:0]            sr;       // tap_access_register
      logic [CMD_W-1:0]            cmd;      // command taken at update
      logic                        tap_pend; // tap transaction queued
      logic                        busy;     // tap_busy_flag
      logic                        wrote;    // tap_wrote_flag
      logic                        lock_sw;  // lock set by tap write
      logic [3:0]                  lk_cnt;   // wake lock counter
      logic                        lock_q;   // tap_lock_flag
      logic [DATA_W-1:0]           held;     // last tap read result
      logic                        fab_pend; // fabric request queued
      logic                        fab_we;
      logic [ADDR_W-1:0]           fab_addr;
      logic [DATA_W-1:0]           fab_di;
      logic [DATA_W-1:0]           port_do;
      logic                        port_rdy;
      logic [DEPTH-1:0][DATA_W-1:0] regs;    // port registers
      logic                        aux_en;
      logic                        conv_rst;
      logic [FD-1:0][CMD_W-1:0]    cq;       // command fifo
      logic [FD-1:0][CMD_W-1:0]    rq;       // read data fifo
      logic [CW-1:0]               cq_n;
      logic [CW-1:0]               rq_n;
      logic                        cq_rdy;
      logic                        rdv;      // proc_rd_valid
      logic                        irq;
      logic [7:0]                  alm_d;    // alarm history
   } jpa_st_t;

   jpa_st_t st_r;
   jpa_st_t st_nxt;

   // ------
   // helpers
   // ------
   // register lookup, zero beyond the stored range
   function automatic logic [DATA_W-1:0] reg_rd(
      input logic [DEPTH-1:0][DATA_W-1:0] r,
      input logic [ADDR_W-1:0]            a);
      logic [DATA_W-1:0] v;
      v = REG_RST;
      if ((a >> REG_AW) == '0) begin
         v = r[a[REG_AW-1:0]];
      end
      return v;
   endfunction

   // stored-range check for writes
   function automatic logic in_range(input logic [ADDR_W-1:0] a);
      return (a >> REG_AW) == '0;
   endfunction

   // command field extraction
   function automatic logic [OP_W-1:0] op_of(input logic [CMD_W-1:0] c);
      return c[OP_LSB +: OP_W];
   endfunction

   function automatic logic [ADDR_W-1:0] adr_of(input logic [CMD_W-1:0] c);
      return c[ADR_LSB +: ADDR_W];
   endfunction

   logic              tck_rise;  // sampled tck rising edge
   logic              lock_all;  // software or wake lock
   logic              tap_ok_q;  // tap may act on the port
   logic [OP_W-1:0]   c_op;
   logic [ADDR_W-1:0] c_adr;
   logic [DATA_W-1:0] c_dat;
   assign tck_rise = st_r.s2[SY_TCK] & ~st_r.tck_d;
   assign lock_all = st_r.lock_q;
   assign tap_ok_q = st_r.ins_s[1] & ~proc_en;
   assign c_op     = op_of(st_r.cmd);
   assign c_adr    = adr_of(st_r.cmd);
   assign c_dat    = st_r.cmd[DAT_LSB +: DATA_W];

   // ------
   // next state
   // ------
   always_comb begin
      jpa_st_t n;
      n = st_r;
      // two-stage sync; s1 feeds only s2
      n.s1 = {clk_missing, tap_update, tap_shift, tap_capture, tdi, tck};
      n.s2 = st_r.s1;
      n.tck_d = st_r.s2[SY_TCK];
      n.ins_s = {st_r.ins_s[0], port_access_instruction};
      n.port_rdy = 1'b0;
      n.conv_rst = 1'b0;

      // wake lock counts up after reset or clock loss
      // hold lock on clock wake
      if (st_r.s2[SY_MIS]) begin
         n.lk_cnt = 4'h0;
      end else if (st_r.lk_cnt != WAKE_C) begin
         n.lk_cnt = st_r.lk_cnt + 4'h1;
      end

      // fabric request latch
      // locked fabric requests dropped
      if (port_en && !lock_all && !st_r.fab_pend) begin
         n.fab_pend = 1'b1;
         n.fab_we   = port_we;
         n.fab_addr = port_addr;
         n.fab_di   = port_di;
      end

      // arbitration, one transaction per visit
      unique case (st_r.arb)
         ARB_IDLE: begin
            if (st_r.tap_pend) begin
               n.arb = ARB_TAP;
            end else if (st_r.fab_pend && !lock_all) begin
               n.arb = ARB_FAB;
            end
         end
         ARB_FAB: begin
            if (st_r.fab_we && in_range(st_r.fab_addr)) begin
               n.regs[st_r.fab_addr[REG_AW-1:0]] = st_r.fab_di;
            end
            n.port_do  = reg_rd(st_r.regs, st_r.fab_addr);
            // ready only when no tap owns port
            n.port_rdy = 1'b1;
            n.fab_pend = 1'b0;
            n.wrote    = 1'b0;
            n.arb      = ARB_IDLE;
         end
         ARB_TAP: begin
            if (c_op == OP_READ) begin
               n.held = reg_rd(st_r.regs, c_adr);
            end else if (c_op == OP_WRITE) begin
               n.wrote = 1'b1;
               if (c_adr == ADR_AUX) begin
                  if (c_dat == AUX_ON && !configured) begin
                     n.aux_en = 1'b1;
                  end
               end else if (in_range(c_adr)) begin
                  n.regs[c_adr[REG_AW-1:0]] = c_dat;
               end
               if (c_adr == ADR_LOCK && c_dat == LOCK_ON) begin
                  n.lock_sw = 1'b1;
               end else if (c_adr == ADR_LOCK && c_dat == LOCK_OFF) begin
                  n.lock_sw = 1'b0;
               end
               if (c_adr == ADR_RST) begin
                  n.conv_rst = 1'b1;
               end
            end
            n.busy     = 1'b0;
            n.tap_pend = 1'b0;
            n.arb      = ARB_IDLE;
         end
      endcase

      // tap scan actions on sampled tck rise
      if (tck_rise && tap_ok_q) begin
         if (st_r.s2[SY_CAP]) begin
            n.sr = {UPPER_Z, st_r.held};
         end else if (st_r.s2[SY_SH]) begin
            n.sr = {st_r.s2[SY_TDI], st_r.sr[CMD_W-1:1]};
         end else if (st_r.s2[SY_UPD]) begin
            n.cmd      = st_r.sr;
            n.tap_pend = 1'b1;
            n.busy     = 1'b1;
         end
      end

      // processor read fifo drain
      if (proc_rd_ready && st_r.rq_n != '0) begin
         for (int i = 0; i < FD - 1; i++) begin
            n.rq[i] = st_r.rq[i+1];
         end
         n.rq_n = st_r.rq_n - CW'(1);
      end

      // one command issues like one scan
      if (proc_en && st_r.cq_n != '0 && !st_r.tap_pend && !st_r.busy
          && n.rq_n != FD_C) begin
         n.rq[n.rq_n] = {UPPER_Z, st_r.held};
         n.rq_n       = n.rq_n + CW'(1);
         n.cmd        = st_r.cq[0];
         n.tap_pend   = 1'b1;
         n.busy       = 1'b1;
         for (int i = 0; i < FD - 1; i++) begin
            n.cq[i] = st_r.cq[i+1];
         end
         n.cq_n = st_r.cq_n - CW'(1);
      end

      // command fifo fill; ready came from last cycle
      if (proc_cmd_valid && st_r.cq_rdy) begin
         n.cq[n.cq_n] = proc_cmd_data;
         n.cq_n       = n.cq_n + CW'(1);
      end
      // registered ready, valid and lock keep the outputs flops
      n.cq_rdy = (n.cq_n != FD_C);
      n.rdv    = (n.rq_n != '0);
      n.lock_q = n.lock_sw | (n.lk_cnt != WAKE_C);

      n.alm_d  = {over_temp_alarm, alarm_flags};
      n.irq    = proc_en & (|({over_temp_alarm, alarm_flags} & ~st_r.alm_d));

      st_nxt = n;
   end

   // ------
   // state register
   // ------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r        <= '0;
         st_r.arb    <= ARB_IDLE;
         st_r.lock_q <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------
   // outputs, all from flops
   // ------
   assign tdo               = st_r.sr[0];
   assign port_do           = st_r.port_do;
   assign port_ready_strobe = st_r.port_rdy;
   assign tap_busy_flag     = st_r.busy;
   assign tap_wrote_flag    = st_r.wrote;
   // wake lock and software lock share flag
   assign tap_lock_flag     = st_r.lock_q;
   assign aux_enable        = st_r.aux_en;
   assign conv_reset        = st_r.conv_rst;
   assign osc_select        = st_r.s2[SY_MIS];
   assign proc_cmd_ready    = st_r.cq_rdy;
   assign proc_rd_valid     = st_r.rdv;
   assign proc_rd_data      = st_r.rq[0];
   assign proc_irq          = st_r.irq;

   // ------
   // checks
   // ------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   chk_busy_rise: assert property (
      tck_rise && tap_ok_q && st_r.s2[SY_UPD] && !st_r.s2[SY_CAP]
      && !st_r.s2[SY_SH] |=> tap_busy_flag && st_r.tap_pend)
      else $error("busy not raised at update");

   chk_tap_done: assert property (
      $rose(tap_busy_flag) |-> ##[1:10] st_r.arb == ARB_TAP)
      else $error("tap access late");

   chk_cap_upper: assert property (
      tck_rise && tap_ok_q && st_r.s2[SY_CAP]
      |=> st_r.sr[CMD_W-1:DATA_W] == UPPER_Z && st_r.sr[DATA_W-1:0] == $past(st_r.held))
      else $error("capture word wrong");

   chk_lock_refuse: assert property (
      tap_lock_flag && port_en && !st_r.fab_pend |=> !st_r.fab_pend)
      else $error("locked fabric request taken");

   chk_tap_first: assert property (
      st_r.arb == ARB_IDLE && st_r.tap_pend && st_r.fab_pend
      |=> st_r.arb == ARB_TAP ##1 st_r.arb == ARB_IDLE)
      else $error("fabric jumped tap");

   chk_undef_op: assert property (
      st_r.arb == ARB_TAP && c_op != OP_READ && c_op != OP_WRITE
      |=> $stable(st_r.held) && $stable(st_r.regs) && $stable(st_r.wrote))
      else $error("undefined op acted");

   chk_aux_keep: assert property (
      st_r.arb == ARB_TAP && c_op == OP_WRITE && c_adr == ADR_AUX
      |=> $stable(st_r.regs))
      else $error("aux write altered register");

   chk_rst_pulse: assert property (
      st_r.arb == ARB_TAP && c_op == OP_WRITE && c_adr == ADR_RST
      |=> conv_reset ##1 !conv_reset)
      else $error("converter reset pulse wrong");

   chk_wake_bound: assert property (
      !st_r.lock_sw && !st_r.s2[SY_MIS] && st_r.lk_cnt == 4'h0
      |-> ##[1:10] !tap_lock_flag || st_r.lock_sw || st_r.s2[SY_MIS])
      else $error("wake lock too long");

   chk_wrote_set: assert property (
      st_r.arb == ARB_TAP && c_op == OP_WRITE |=> tap_wrote_flag)
      else $error("modified flag not set");

   cov_tap_read: cover property (st_r.arb == ARB_TAP && c_op == OP_READ);
   cov_fab_queued: cover property (
      st_r.fab_pend && tap_busy_flag ##[1:20] port_ready_strobe);
   cov_proc_cmd: cover property (proc_en && $fell(st_r.cq_n == '0));
   cov_lock_on: cover property ($rose(st_r.lock_sw));
endmodule

/* File: tb/jpa_tap_host.sv */
/*
 tap host model: drives access register scans.
 assumes: bench calls scan(); tck stands low between scans.
*/
`timescale 1ns/1ps
module jpa_tap_host (
   output logic      tck,
   output logic      tdi,
   output logic      tap_capture,
   output logic      tap_shift,
   output logic      tap_update,
   input  wire logic tdo
);
   localparam time HALF = 200;  // 400 ns tck
   initial begin
      tck = 1'h0;
      tdi = 1'h0;
      tap_capture = 1'h0;
      tap_shift = 1'h0;
      tap_update = 1'h0;
   end
   // one tck period, levels set while tck is low
   task automatic pulse();
      #HALF;
      tck = 1'h1;
      #HALF;
      tck = 1'h0;
   endtask
   // capture, 32 shifts lsb first, update
   task automatic scan(input logic [31:0] din, input int idle, output logic [31:0] dout);
      tap_capture = 1'h1;
      pulse();
      tap_capture = 1'h0;
      tap_shift = 1'h1;
      for (int i = 0; i < 32; i++) begin
         tdi = din[i];
         #HALF;
         dout[i] = tdo;
         tck = 1'h1;
         #HALF;
         tck = 1'h0;
      end
      tap_shift = 1'h0;
      // released data line: inverse of the last bit
      tdi = ~tdi;
      tap_update = 1'h1;
      pulse();
      tap_update = 1'h0;
      // idle states before the next scan
      repeat (idle) pulse();
   endtask
endmodule

/* File: tb/tb_jpa_arbiter.sv */
/*
 self-checking bench for the tap port-access arbiter.
 assumes: jpa_pkg and jpa_tap_host compiled first; clk 20 MHz.
*/
`timescale 1ns/1ps
module tb_jpa_arbiter
   import jpa_pkg::*;
;
   // ------
   // signals
   // ------
   logic              clk = 1'h0, rstn = 1'h0;
   logic              tck, tdi, tap_capture, tap_shift, tap_update, tdo;
   logic              port_en = 1'h0, port_we = 1'h0;     // fabric request
   logic [ADDR_W-1:0] port_addr = 10'h0;
   logic [DATA_W-1:0] port_di = 16'h0, port_do;
   logic              port_ready_strobe, tap_busy_flag, tap_wrote_flag, tap_lock_flag;
   logic              configured = 1'h0, aux_enable, conv_reset, osc_select;
   logic              proc_en = 1'h0, proc_cmd_valid = 1'h0, proc_cmd_ready;
   logic [CMD_W-1:0]  proc_cmd_data = 32'h0, proc_rd_data;
   logic              proc_rd_valid, proc_rd_ready = 1'h0, proc_irq;
   logic              busy_seen = 1'h0;                     // busy ever high
   logic              instr_sel = 1'h1;                     // access instruction selected
   int                error_cnt = 0, n_tests = 0;
   int                busy_len = 0, busy_max = 0, rst_cnt = 0;
   // ------
   // design and far side
   // ------
   jpa_arbiter u_dut (
      .clk(clk), .rstn(rstn), .tck(tck), .tdi(tdi), .tap_capture(tap_capture),
      .tap_shift(tap_shift), .tap_update(tap_update), .port_access_instruction(instr_sel),
      .tdo(tdo), .port_en(port_en), .port_we(port_we), .port_addr(port_addr),
      .port_di(port_di), .port_do(port_do), .port_ready_strobe(port_ready_strobe),
      .tap_busy_flag(tap_busy_flag), .tap_wrote_flag(tap_wrote_flag),
      .tap_lock_flag(tap_lock_flag), .configured(configured), .clk_missing(1'h0),
      .aux_enable(aux_enable), .conv_reset(conv_reset), .osc_select(osc_select),
      .proc_en(proc_en), .proc_cmd_valid(proc_cmd_valid), .proc_cmd_data(proc_cmd_data),
      .proc_cmd_ready(proc_cmd_ready), .proc_rd_valid(proc_rd_valid),
      .proc_rd_data(proc_rd_data), .proc_rd_ready(proc_rd_ready),
      .over_temp_alarm(1'h0), .alarm_flags(7'h00), .proc_irq(proc_irq));
   jpa_tap_host u_host (.tck(tck), .tdi(tdi), .tap_capture(tap_capture),
      .tap_shift(tap_shift), .tap_update(tap_update), .tdo(tdo));
   always #25 clk = ~clk;
   // ------
   // helpers
   // ------
   task automatic fail(input string m);
      $display("[ERR] %0t %s", $time, m);
      error_cnt++;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) fail(m);
   endtask
   task automatic report_and_stop();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic hang(input string m);
      fail(m);
      report_and_stop();
   endtask
   // sample just after an edge, once updates have landed
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic tap(input logic [3:0] op, input logic [9:0] a, input logic [15:0] d,
                      output logic [31:0] q);
      u_host.scan({2'h0, op, a, d}, 12, q);
   endtask
   // one fabric access; caller stands just after an edge
   task automatic fab(input logic we, input logic [9:0] a, input logic [15:0] d,
                      input logic ok, output logic [15:0] q);
      int n;
      n = 0;
      port_en <= 1'h1;
      port_we <= we;
      port_addr <= a;
      port_di <= d;
      @(posedge clk);
      port_en <= 1'h0;
      // look at the strobe only once this edge has settled
      #1;
      // no new request before the strobe
      while (port_ready_strobe !== 1'h1 && n < 40) begin
         step();
         n++;
      end
      q = port_do;
      if (ok && n == 40) hang("fabric strobe missing");
      if (!ok) chk(n, 40, "locked fabric request answered");
   endtask
   // tap busy length, reset pulses, strobe against busy
   always @(posedge clk) begin
      busy_len <= (tap_busy_flag === 1'h1) ? busy_len + 1 : 0;
      if (busy_len > busy_max) busy_max <= busy_len;
      if (tap_busy_flag === 1'h1) busy_seen <= 1'h1;
      if (conv_reset === 1'h1) rst_cnt <= rst_cnt + 1;
      // fabric strobe while tap busy counts as an error
      if (port_ready_strobe === 1'h1 && tap_busy_flag === 1'h1) fail("strobe during busy");
   end
   // ------
   // scenarios
   // ------
   task automatic t_wake();
      int n;
      n = 0;
      chk(tap_lock_flag, 32'h1, "lock low at wake");
      while (tap_lock_flag === 1'h1 && n < 20) begin
         step();
         n++;
      end
      chk(n <= LOCK_WAKE_CYC, 32'h1, "wake lock too long");
   endtask
   task automatic t_wr();
      logic [31:0] q;
      tap(OP_WRITE, 10'h005, 16'hA5C3, q);
      chk(tap_wrote_flag, 32'h1, "modified flag not set");
      chk(busy_seen, 32'h1, "busy never raised");
      tap(OP_WRITE, 10'h006, 16'h3C5A, q);
      tap(OP_READ, 10'h005, 16'h0000, q);
      tap(OP_READ, 10'h006, 16'h0000, q);
      chk(q, {UPPER_Z, 16'hA5C3}, "first pipelined read");
      tap(OP_NOP, 10'h000, 16'h0000, q);
      chk(q, {UPPER_Z, 16'h3C5A}, "second pipelined read");
   endtask
   task automatic t_fab();
      logic [15:0] v;
      fab(1'h0, 10'h005, 16'h0000, 1'h1, v);
      chk(v, 32'hA5C3, "fabric read of tap data");
      chk(tap_wrote_flag, 32'h0, "modified flag not cleared");
      fab(1'h1, 10'h007, 16'h0F0F, 1'h1, v);
      fab(1'h0, 10'h007, 16'h0000, 1'h1, v);
      chk(v, 32'h0F0F, "fabric write readback");
   endtask
   task automatic t_ops();
      logic [31:0] q;
      for (int op = 3; op < 16; op++) begin
         tap(4'(op), 10'h005, 16'hFFFF, q);
      end
      chk(tap_wrote_flag, 32'h0, "undefined op wrote");
      tap(OP_READ, 10'h005, 16'h0000, q);
      tap(OP_NOP, 10'h000, 16'h0000, q);
      chk(q, {UPPER_Z, 16'hA5C3}, "undefined op changed data");
   endtask
   task automatic t_lock();
      logic [31:0] q;
      logic [15:0] v;
      tap(OP_WRITE, ADR_LOCK, LOCK_ON, q);
      chk(tap_lock_flag, 32'h1, "lock not set");
      fab(1'h1, 10'h007, 16'h1111, 1'h0, v);
      tap(OP_WRITE, ADR_LOCK, LOCK_OFF, q);
      chk(tap_lock_flag, 32'h0, "lock not cleared");
      fab(1'h0, 10'h007, 16'h0000, 1'h1, v);
      chk(v, 32'h0F0F, "locked write landed");
   endtask
   task automatic t_aux();
      logic [31:0] q;
      logic [15:0] v, w;
      fab(1'h0, ADR_AUX, 16'h0000, 1'h1, v);
      configured <= 1'h1;
      tap(OP_WRITE, ADR_AUX, AUX_ON, q);
      chk(aux_enable, 32'h0, "aux enabled after config");
      configured <= 1'h0;
      tap(OP_WRITE, ADR_AUX, AUX_ON, q);
      chk(aux_enable, 32'h1, "aux not enabled");
      fab(1'h0, ADR_AUX, 16'h0000, 1'h1, w);
      chk(w, v, "aux write altered result");
   endtask
   task automatic t_rst();
      logic [31:0] q;
      int b;
      b = rst_cnt;
      tap(OP_WRITE, ADR_RST, 16'hBEEF, q);
      chk(rst_cnt - b, 32'h1, "converter reset not pulsed once");
   endtask
   task automatic t_arb();
      logic [31:0] q;
      logic [15:0] v;
      int n;
      n = 0;
      fork
         tap(OP_WRITE, 10'h009, 16'h1234, q);
         begin
            while (tap_busy_flag !== 1'h1 && n < 2000) begin
               step();
               n++;
            end
            if (n == 2000) hang("busy never seen");
            fab(1'h0, 10'h009, 16'h0000, 1'h1, v);
         end
      join
      chk(v, 32'h1234, "queued fabric read ran first");
      chk(busy_max <= TAP_DONE_CYC, 32'h1, "tap write too slow");
   endtask
   task automatic push(input logic [31:0] w);
      logic r;
      proc_cmd_valid <= 1'h1;
      proc_cmd_data <= w;
      @(posedge clk);
      r = proc_cmd_ready;
      proc_cmd_valid <= 1'h0;
      chk(r, 32'h1, "command fifo refused");
      step();
   endtask
   task automatic pop(output logic [31:0] w);
      int n;
      n = 0;
      while (proc_rd_valid !== 1'h1 && n < 100) begin
         step();
         n++;
      end
      if (n == 100) hang("read fifo empty");
      w = proc_rd_data;
      proc_rd_ready <= 1'h1;
      @(posedge clk);
      proc_rd_ready <= 1'h0;
      step();
   endtask
   task automatic t_proc();
      logic [31:0] q;
      proc_en <= 1'h1;
      tap(OP_WRITE, ADR_LOCK, LOCK_ON, q);
      chk(tap_lock_flag, 32'h0, "tap reached port under processor");
      push({2'h0, OP_READ, 10'h007, 16'h0000});
      push({2'h0, OP_NOP, 10'h000, 16'h0000});
      pop(q);
      chk(q, {UPPER_Z, 16'hA5C3}, "processor stale word");
      pop(q);
      chk(q, {UPPER_Z, 16'h0F0F}, "processor read result");
      proc_en <= 1'h0;
      instr_sel <= 1'h0;
      tap(OP_WRITE, ADR_LOCK, LOCK_ON, q);
      chk(tap_lock_flag, 32'h0, "tap acted without instruction");
      instr_sel <= 1'h1;
      step();
   endtask
   // ------
   // main sequence
   // ------
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'h1;
      t_wake();
      t_wr();
      t_fab();
      t_ops();
      t_lock();
      t_aux();
      t_rst();
      t_arb();
      t_proc();
      report_and_stop();
   end
endmodule
